// >>> design/i50r_pkg.sv
// constants for the source-50 routing and priority slice
package i50r_pkg;
  localparam int         LEVEL_W        = 3;
  localparam int         COND_W         = 2;
  localparam int         CHAN_W         = 2;
  localparam logic [2:0] LEVEL_DISABLED = 3'h0;
  localparam logic [2:0] CHAN_LIMIT     = 3'h3;
  localparam logic       ROUTE_RST      = 1'h0;
  localparam logic [2:0] LEVEL_RST      = 3'h0;
  localparam logic [1:0] COND_RST       = 2'h0;
  localparam logic [1:0] COND_TIMER     = 2'h3;
endpackage : i50r_pkg

// >>> design/i50r_route.sv
// configuration and routing of interrupt source 50 (third 16-bit timer)
`timescale 1ns/1ps

// Function
// - with the route select clear the source is never sent to the DMA controller and goes to the CPU path.
// - with the route select set and a level of 0 to 3, an assertion of the source becomes a DMA start request instead of a CPU interrupt.
// - with the route select clear the level field is the priority, zero disabling and 1 to 7 giving the level.
// - with the route select set the level field names DMA channel 0 to 3, and 4 to 7 is an invalid setting.
// - after reset route select, level and active-condition fields all read zero.
module i50r_route
  import i50r_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // configuration write port from the cpu bus
  input  wire logic                cfgWe,
  input  wire logic                cfgRouteSel,
  input  wire logic [LEVEL_W-1:0]  cfgLevel,
  input  wire logic [COND_W-1:0]   cfgCond,
  // configuration readback
  output logic                     src50DmaRouteSel,
  output logic [LEVEL_W-1:0]       src50Level,
  output logic [COND_W-1:0]        src50ActiveCond,
  // interrupt source from the timer, same clock
  input  wire logic                timer3Irq,
  // cpu interrupt request
  output logic                     cpuIrqReq,
  output logic [LEVEL_W-1:0]       cpuIrqLevel,
  // dma controller start request
  output logic                     dmaStartReq,
  output logic [CHAN_W-1:0]        dmaChannel,
  output logic                     dmaCfgInvalid,
  // active condition not the one required for this source
  output logic                     condMismatch
);

  logic               routeSel_reg, routeSel_next;
  logic [LEVEL_W-1:0] level_reg, level_next;
  logic [COND_W-1:0]  cond_reg, cond_next;
  logic               cpuIrq_reg, cpuIrq_next;
  logic [LEVEL_W-1:0] irqLvl_reg, irqLvl_next;
  logic               dmaReq_reg, dmaReq_next;
  logic [CHAN_W-1:0]  dmaCh_reg, dmaCh_next;
  logic               chanOk;
  // status flags are kept in flip-flops so that every data output is registered
  logic               dmaInv_reg, dmaInv_next;
  logic               condMis_reg, condMis_next;

  // the field slicing below assumes the widths of the package
  if (LEVEL_W != 3) begin : g_level_w_check
    $error("level field must be three bits wide");
  end
  if (COND_W != 2) begin : g_cond_w_check
    $error("active-condition field must be two bits wide");
  end
  if (CHAN_W != 2 || CHAN_W >= LEVEL_W) begin : g_chan_w_check
    $error("channel number must be two bits and narrower than the level field");
  end

  always_comb begin
    routeSel_next = routeSel_reg;
    level_next    = level_reg;
    cond_next     = cond_reg;
    if (cfgWe) begin
      routeSel_next = cfgRouteSel;
      level_next    = cfgLevel;
      cond_next     = cfgCond;
    end
    // flags follow the values that the registers will hold after this edge,
    // so they change in the same cycle as the readback
    dmaInv_next  = routeSel_next && (level_next > CHAN_LIMIT);
    condMis_next = (cond_next != COND_TIMER);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      routeSel_reg <= ROUTE_RST;
      level_reg    <= LEVEL_RST;
      cond_reg     <= COND_RST;
      dmaInv_reg   <= 1'b0;
      // reset value of the condition field is not the timer value
      condMis_reg  <= (COND_RST != COND_TIMER);
    end else begin
      routeSel_reg <= routeSel_next;
      level_reg    <= level_next;
      cond_reg     <= cond_next;
      dmaInv_reg   <= dmaInv_next;
      condMis_reg  <= condMis_next;
    end
  end

  assign chanOk = (level_reg <= CHAN_LIMIT);

  always_comb begin
    // cpu path only when not routed and level nonzero
    cpuIrq_next = timer3Irq && !routeSel_reg && (level_reg != LEVEL_DISABLED);
    irqLvl_next = routeSel_reg ? LEVEL_DISABLED : level_reg;
    // dma path only when routed to a valid channel
    dmaReq_next = timer3Irq && routeSel_reg && chanOk;
    dmaCh_next  = level_reg[CHAN_W-1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpuIrq_reg <= 1'b0;
      irqLvl_reg <= LEVEL_RST;
      dmaReq_reg <= 1'b0;
      dmaCh_reg  <= 2'h0;
    end else begin
      cpuIrq_reg <= cpuIrq_next;
      irqLvl_reg <= irqLvl_next;
      dmaReq_reg <= dmaReq_next;
      dmaCh_reg  <= dmaCh_next;
    end
  end

  assign src50DmaRouteSel = routeSel_reg;
  assign src50Level       = level_reg;
  assign src50ActiveCond  = cond_reg;
  assign cpuIrqReq        = cpuIrq_reg;
  assign cpuIrqLevel      = irqLvl_reg;
  assign dmaStartReq      = dmaReq_reg;
  assign dmaChannel       = dmaCh_reg;
  assign dmaCfgInvalid    = dmaInv_reg;
  assign condMismatch     = condMis_reg;

  // routed source never reaches the cpu
  no_cpu_when_dma_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(routeSel_reg) |-> !cpuIrqReq) else $error("cpu request while routed to dma");
  no_dma_when_cpu_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(routeSel_reg) |-> !dmaStartReq) else $error("dma request while not routed");
  cpu_irq_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
    (timer3Irq && !routeSel_reg && level_reg != 3'h0) |=> (cpuIrqReq && cpuIrqLevel == $past(level_reg)))
    else $error("cpu request missing or wrong level");
  level_zero_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (level_reg == 3'h0) |=> !cpuIrqReq) else $error("disabled level raised request");
  dma_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (timer3Irq && routeSel_reg && level_reg <= 3'h3) |=> (dmaStartReq && dmaChannel == $past(level_reg[1:0])))
    else $error("dma start missing or wrong channel");
  dma_invalid_a: assert property (@(posedge clk) disable iff (!rst_n)
    (routeSel_reg && level_reg[2]) |=> !dmaStartReq) else $error("invalid channel started dma");
  reset_clear_a: assert property (@(posedge clk)
    !rst_n |=> (!src50DmaRouteSel && src50Level == 3'h0 && src50ActiveCond == 2'h0))
    else $error("config not zero after reset");
  reset_quiet_a: assert property (@(posedge clk)
    !rst_n |=> (!cpuIrqReq && !dmaStartReq)) else $error("request right after reset");

  // flags out of reset: not invalid, condition not yet the timer value
  reset_flags_a: assert property (@(posedge clk)
    !rst_n |=> (!dmaCfgInvalid && condMismatch))
    else $error("status flags wrong after reset");

  // the two request paths never fire together
  path_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(cpuIrqReq && dmaStartReq))
    else $error("cpu and dma requests together");

  // no source, no request on either path
  idle_no_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    !timer3Irq |=> (!cpuIrqReq && !dmaStartReq))
    else $error("request without source");

  // level output reads zero while the source is routed to dma
  cpu_level_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    routeSel_reg |=> (cpuIrqLevel == 3'h0))
    else $error("cpu level shown while routed");

  // level output carries the priority while on the cpu path
  cpu_level_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    !routeSel_reg |=> (cpuIrqLevel == $past(level_reg)))
    else $error("cpu level not the programmed priority");

  // channel output carries the low level bits
  dma_chan_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    routeSel_reg |=> (dmaChannel == $past(level_reg[1:0])))
    else $error("dma channel not the programmed one");

  // invalid flag tracks the readback fields
  invalid_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    dmaCfgInvalid == (src50DmaRouteSel && src50Level[2]))
    else $error("invalid flag disagrees with fields");

  // condition flag tracks the readback field
  cond_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    condMismatch == (src50ActiveCond != COND_TIMER))
    else $error("condition flag disagrees with field");

  // a write lands in the readback one edge later
  cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfgWe |=> (src50DmaRouteSel == $past(cfgRouteSel) && src50Level == $past(cfgLevel)
               && src50ActiveCond == $past(cfgCond)))
    else $error("configuration write lost");

  // without a write the configuration holds
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cfgWe |=> ($stable(src50DmaRouteSel) && $stable(src50Level) && $stable(src50ActiveCond)))
    else $error("configuration changed without write");

endmodule : i50r_route

// >>> test/i50r_route_tb_top.sv
// self-checking bench for the source-50 routing slice
`timescale 1ns/1ps
module i50r_route_tb_top
  import i50r_pkg::*;
();
  logic       clk = 1'b0, rst_n = 1'b0, cfgWe = 1'b0, cfgRouteSel = 1'b0, timer3Irq = 1'b0;
  logic [2:0] cfgLevel = 3'h0, src50Level, cpuIrqLevel, l;
  logic [1:0] cfgCond = 2'h0, src50ActiveCond, dmaChannel, c;
  logic       src50DmaRouteSel, cpuIrqReq, dmaStartReq, dmaCfgInvalid, condMismatch, r;
  logic [7:0] expReq;
  int         err_count = 0, samples_checked = 0, seed = 5;

  always #12.5 clk = ~clk;

  i50r_route dut (.clk(clk), .rst_n(rst_n), .cfgWe(cfgWe), .cfgRouteSel(cfgRouteSel), .cfgLevel(cfgLevel),
    .cfgCond(cfgCond), .src50DmaRouteSel(src50DmaRouteSel), .src50Level(src50Level),
    .src50ActiveCond(src50ActiveCond), .timer3Irq(timer3Irq), .cpuIrqReq(cpuIrqReq), .cpuIrqLevel(cpuIrqLevel),
    .dmaStartReq(dmaStartReq), .dmaChannel(dmaChannel), .dmaCfgInvalid(dmaCfgInvalid), .condMismatch(condMismatch));

  // requests use the configuration held when the source was sampled
  function automatic logic [7:0] exp_req(logic irq, logic rs, logic [2:0] lv);
    return {irq & ~rs & (lv != 3'h0), rs ? 3'h0 : lv, irq & rs & ~lv[2], lv[1:0], 1'b0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    r = 1'b0;
    l = 3'h0;
    c = 2'h0;
    expReq = 8'h00;
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #2;
      chk({2'h0, src50DmaRouteSel, src50Level, src50ActiveCond}, {2'h0, r, l, c});
      chk({cpuIrqReq, cpuIrqLevel, dmaStartReq, dmaChannel, 1'b0}, expReq);
      chk({6'h0, dmaCfgInvalid, condMismatch}, {6'h0, r & l[2], c != COND_TIMER});
      // first sixteen cycles write every level under both routes with the source raised; route set with level 7 then meets a random source
      cfgWe = 1'($random(seed)) | (i < 16);
      cfgRouteSel = (i < 16) ? i[3] : 1'($random(seed));
      cfgLevel = (i < 16) ? i[2:0] : 3'($random(seed));
      cfgCond = (i < 16) ? COND_TIMER : 2'($random(seed));
      timer3Irq = 1'($random(seed)) | (i < 16);
      rst_n = (i != 200);
      expReq = exp_req(timer3Irq, r, l);
      if (cfgWe) begin
        r = cfgRouteSel;
        l = cfgLevel;
        c = cfgCond;
      end
      if (!rst_n) begin
        r = 1'b0;
        l = 3'h0;
        c = 2'h0;
        expReq = 8'h00;
      end
    end
    end_of_test;
  end
endmodule // i50r_route_tb_top
